// ### amcr_regs.sv
// Purpose: APB register bank for the mixer and record path controls
// Assumes: APB slave, zero-wait, byte address = index * 4
// Notes:   16-bit registers sit in the low half of each word
`timescale 1ns/1ps
`include "amcr_cfg.svh"
module amcr_regs (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 clk_en,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output amcr_pkg::amcr_word_t      phone_ctrl,
	output amcr_pkg::amcr_word_t      mic_ctrl,
	output logic      [4:0]           line_left_gain,
	output logic      [4:0]           line_right_gain,
	output logic      [4:0]           cd_left_gain,
	output logic      [4:0]           cd_right_gain,
	output logic      [4:0]           video_left_gain,
	output logic      [4:0]           video_right_gain,
	output logic      [4:0]           aux_left_gain,
	output logic      [4:0]           aux_right_gain,
	output logic      [4:0]           pcm_left_gain,
	output logic      [4:0]           pcm_right_gain,
	output logic signed [7:0]         mic_gain_half_db,
	output amcr_pkg::amcr_rec_src_e   left_rec_source,
	output amcr_pkg::amcr_rec_src_e   right_rec_source,
	output logic      [3:0]           rec_left_gain,
	output logic      [3:0]           rec_right_gain,
	output logic                      rec_muted,
	output logic                      spatial_enable,
	output logic      [3:0]           depth_level,
	output logic      [1:0]           double_rate_slot_select,
	output logic                      slot_select_reserved,
	output logic                      mono_out_is_mic,
	output logic                      converter_loop,
	output logic      [1:0]           boost_left_mic,
	output logic      [1:0]           boost_right_mic,
	output logic                      shared_pins_outputs
);
	import amcr_pkg::*;
	localparam int NCH = 5;
	localparam logic [6:0] CH_IDX [NCH] = '{`AMCR_IDX_LINE, `AMCR_IDX_CD,
		`AMCR_IDX_VIDEO, `AMCR_IDX_AUX, `AMCR_IDX_PCM};

	amcr_state_e state_reg;
	logic [31:0] prdata_reg;
	logic        err_reg;
	logic        setup;
	logic        wr_req;
	logic        rd_req;
	logic [6:0]  idx;
	logic        addr_ok;
	logic        hit_known;
	logic        soft_rst;
	logic [15:0] wdata16;
	logic [15:0] rd_val;
	logic [15:0] phone_reg;
	logic [15:0] mic_reg;
	logic [15:0] recsel_reg;
	logic [15:0] recgain_reg;
	logic [15:0] gp_reg;
	logic [15:0] depth_reg;
	logic [15:0] route_reg;
	logic [15:0] ch_val [NCH];
	logic [4:0]  ch_l [NCH];
	logic [4:0]  ch_r [NCH];
	logic [NCH-1:0] ch_wr;

	assign setup   = psel && !penable && state_reg == AMCR_IDLE;
	assign idx     = paddr[8:2];
	assign addr_ok = paddr[1:0] == 2'b00 && paddr[11:9] == 3'b000;
	// 16-bit registers live in the low two byte lanes
	assign wdata16 = {pstrb[1] ? pwdata[15:8] : rd_val[15:8],
		pstrb[0] ? pwdata[7:0] : rd_val[7:0]};
	assign wr_req   = psel && penable && pwrite && state_reg == AMCR_ACCESS && !err_reg;
	assign rd_req   = setup && !pwrite;
	// write of any data to the reset register restores defaults
	assign soft_rst = wr_req && idx == `AMCR_IDX_RESET;

	always_comb begin
		rd_val    = 16'h0000;
		hit_known = 1'b1;
		if (!addr_ok) begin
			hit_known = 1'b0;
		end else if (idx == `AMCR_IDX_RESET) begin
			rd_val = `AMCR_RST_ID;
		end else if (idx == `AMCR_IDX_PHONE) begin
			rd_val = phone_reg;
		end else if (idx == `AMCR_IDX_MIC) begin
			rd_val = mic_reg;
		end else if (idx == `AMCR_IDX_LINE) begin
			rd_val = ch_val[0];
		end else if (idx == `AMCR_IDX_CD) begin
			rd_val = ch_val[1];
		end else if (idx == `AMCR_IDX_VIDEO) begin
			rd_val = ch_val[2];
		end else if (idx == `AMCR_IDX_AUX) begin
			rd_val = ch_val[3];
		end else if (idx == `AMCR_IDX_PCM) begin
			rd_val = ch_val[4];
		end else if (idx == `AMCR_IDX_RECSEL) begin
			rd_val = recsel_reg;
		end else if (idx == `AMCR_IDX_RECGAIN) begin
			rd_val = recgain_reg;
		end else if (idx == `AMCR_IDX_GP) begin
			rd_val = gp_reg;
		end else if (idx == `AMCR_IDX_DEPTH) begin
			rd_val = depth_reg;
		end else if (idx == `AMCR_IDX_ROUTE) begin
			rd_val = route_reg;
		end else begin
			hit_known = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= AMCR_IDLE;
		end else if (clk_en) begin
			case (state_reg)
				AMCR_IDLE: begin
					if (setup) begin
						state_reg <= AMCR_ACCESS;
					end
				end
				AMCR_ACCESS: begin
					state_reg <= AMCR_IDLE;
				end
				default: begin
					state_reg <= AMCR_IDLE;
				end
			endcase
		end
	end

	// error decided at setup, so the access phase answers in one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg    <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			if (setup) begin
				err_reg    <= !hit_known;
				prdata_reg <= (rd_req && hit_known) ? {16'h0000, rd_val} : 32'h0000_0000;
			end
		end
	end

	assign pready  = state_reg == AMCR_ACCESS;
	assign pslverr = pready && err_reg;
	assign prdata  = prdata_reg;

	// one block per register; masks zero reserved bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phone_reg <= `AMCR_RST_MONO_IN;
		end else if (clk_en) begin
			if (soft_rst) begin
				phone_reg <= `AMCR_RST_MONO_IN;
			end else if (wr_req && idx == `AMCR_IDX_PHONE) begin
				phone_reg <= wdata16 & `AMCR_MSK_MONO_IN;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mic_reg <= `AMCR_RST_MONO_IN;
		end else if (clk_en) begin
			if (soft_rst) begin
				mic_reg <= `AMCR_RST_MONO_IN;
			end else if (wr_req && idx == `AMCR_IDX_MIC) begin
				mic_reg <= wdata16 & `AMCR_MSK_MIC;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recsel_reg <= `AMCR_RST_RECSEL;
		end else if (clk_en) begin
			if (soft_rst) begin
				recsel_reg <= `AMCR_RST_RECSEL;
			end else if (wr_req && idx == `AMCR_IDX_RECSEL) begin
				recsel_reg <= wdata16 & `AMCR_MSK_RECSEL;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recgain_reg <= `AMCR_RST_RECGAIN;
		end else if (clk_en) begin
			if (soft_rst) begin
				recgain_reg <= `AMCR_RST_RECGAIN;
			end else if (wr_req && idx == `AMCR_IDX_RECGAIN) begin
				recgain_reg <= wdata16 & `AMCR_MSK_RECGAIN;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_reg <= `AMCR_RST_GP;
		end else if (clk_en) begin
			if (soft_rst) begin
				gp_reg <= `AMCR_RST_GP;
			end else if (wr_req && idx == `AMCR_IDX_GP) begin
				gp_reg <= wdata16 & `AMCR_MSK_GP;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth_reg <= `AMCR_RST_DEPTH;
		end else if (clk_en) begin
			if (soft_rst) begin
				depth_reg <= `AMCR_RST_DEPTH;
			end else if (wr_req && idx == `AMCR_IDX_DEPTH) begin
				depth_reg <= wdata16 & `AMCR_MSK_DEPTH;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_reg <= `AMCR_RST_ROUTE;
		end else if (clk_en) begin
			if (soft_rst) begin
				route_reg <= `AMCR_RST_ROUTE;
			end else if (wr_req && idx == `AMCR_IDX_ROUTE) begin
				route_reg <= wdata16 & `AMCR_MSK_ROUTE;
			end
		end
	end

	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			assign ch_wr[i] = wr_req && idx == CH_IDX[i];
			amcr_chan #(
				.RST_VAL (`AMCR_RST_STEREO_IN),
				.MASK    (`AMCR_MSK_STEREO_IN)
			) u_chan (
				.pclk      (pclk),
				.presetn   (presetn),
				.clk_en    (clk_en),
				.soft_rst  (soft_rst),
				.wr_en     (ch_wr[i]),
				.wr_data   (wdata16),
				.value     (ch_val[i]),
				.muted     (),
				.left_eff  (ch_l[i]),
				.right_eff (ch_r[i])
			);
		end
	endgenerate

	assign line_left_gain   = ch_l[0];
	assign line_right_gain  = ch_r[0];
	assign cd_left_gain     = ch_l[1];
	assign cd_right_gain    = ch_r[1];
	assign video_left_gain  = ch_l[2];
	assign video_right_gain = ch_r[2];
	assign aux_left_gain    = ch_l[3];
	assign aux_right_gain   = ch_r[3];
	assign pcm_left_gain    = ch_l[4];
	assign pcm_right_gain   = ch_r[4];
	assign phone_ctrl       = phone_reg;
	assign mic_ctrl         = mic_reg;

	amcr_gain u_mic_gain (
		.code    (mic_reg[4:0]),
		.boost   (mic_reg[`AMCR_BIT_BOOST]),
		.half_db (mic_gain_half_db)
	);

	assign left_rec_source  = amcr_rec_src_e'(recsel_reg[10:8]);
	assign right_rec_source = amcr_rec_src_e'(recsel_reg[2:0]);
	// record gain code n is n * 1.5 dB above 0 dB
	assign rec_left_gain    = recgain_reg[11:8];
	assign rec_right_gain   = recgain_reg[3:0];
	assign rec_muted        = recgain_reg[`AMCR_BIT_MUTE];
	assign spatial_enable   = gp_reg[`AMCR_BIT_SPATIAL];
	// depth is linear, 0 to 15 of 15
	assign depth_level      = depth_reg[3:0];
	assign double_rate_slot_select = gp_reg[11:10];
	assign slot_select_reserved = gp_reg[11];
	assign mono_out_is_mic  = gp_reg[`AMCR_BIT_MONO_SRC];
	assign converter_loop   = gp_reg[`AMCR_BIT_LOOP];

	// mic routing: 0=mic1 1=mic2 2=mic3
	logic [2:0] route_sel;
	assign route_sel = {route_reg[`AMCR_BIT_SIX_CH], route_reg[`AMCR_BIT_MIC_SWAP],
		gp_reg[`AMCR_BIT_MIC_CHOOSE]};
	always_comb begin
		boost_left_mic  = 2'd0;
		boost_right_mic = 2'd0;
		case (route_sel)
			3'b000: begin
				boost_left_mic  = 2'd0;
				boost_right_mic = 2'd0;
			end
			3'b001: begin
				boost_left_mic  = 2'd0;
				boost_right_mic = 2'd2;
			end
			3'b010: begin
				boost_left_mic  = 2'd1;
				boost_right_mic = 2'd1;
			end
			3'b011: begin
				boost_left_mic  = 2'd0;
				boost_right_mic = 2'd1;
			end
			3'b100: begin
				boost_left_mic  = 2'd2;
				boost_right_mic = 2'd2;
			end
			3'b101: begin
				boost_left_mic  = 2'd2;
				boost_right_mic = 2'd2;
			end
			3'b110: begin
				boost_left_mic  = 2'd0;
				boost_right_mic = 2'd0;
			end
			default: begin
				boost_left_mic  = 2'd0;
				boost_right_mic = 2'd1;
			end
		endcase
	end
	assign shared_pins_outputs = route_reg[`AMCR_BIT_SIX_CH];
endmodule

// ### amcr_cfg.svh
// Purpose: offsets, field positions, reset values for the mixer control bank
// Assumes: byte addresses on APB, one 32-bit word per register
// Notes:   register offsets are word indices; byte address is index times four
`ifndef AMCR_CFG_SVH
`define AMCR_CFG_SVH
`define AMCR_IDX_RESET      7'h00
`define AMCR_IDX_PHONE      7'h0c
`define AMCR_IDX_MIC        7'h0e
`define AMCR_IDX_LINE       7'h10
`define AMCR_IDX_CD         7'h12
`define AMCR_IDX_VIDEO      7'h14
`define AMCR_IDX_AUX        7'h16
`define AMCR_IDX_PCM        7'h18
`define AMCR_IDX_RECSEL     7'h1a
`define AMCR_IDX_RECGAIN    7'h1c
`define AMCR_IDX_GP         7'h20
`define AMCR_IDX_DEPTH      7'h22
`define AMCR_IDX_ROUTE      7'h7a
`define AMCR_RST_MONO_IN    16'h8008
`define AMCR_RST_STEREO_IN  16'h8808
`define AMCR_RST_RECSEL     16'h0000
`define AMCR_RST_RECGAIN    16'h8000
`define AMCR_RST_GP         16'h0000
`define AMCR_RST_DEPTH      16'h0000
`define AMCR_RST_ROUTE      16'h0000
`define AMCR_RST_ID         16'h0000
`define AMCR_MSK_MONO_IN    16'h801f
`define AMCR_MSK_MIC        16'h805f
`define AMCR_MSK_STEREO_IN  16'h9f1f
`define AMCR_MSK_RECSEL     16'h0707
`define AMCR_MSK_RECGAIN    16'h8f0f
`define AMCR_MSK_GP         16'h2f80
`define AMCR_MSK_DEPTH      16'h000f
`define AMCR_MSK_ROUTE      16'hc000
`define AMCR_BIT_MUTE       15
`define AMCR_BIT_BOOST      6
`define AMCR_BIT_SPATIAL    13
`define AMCR_BIT_MONO_SRC   9
`define AMCR_BIT_MIC_CHOOSE 8
`define AMCR_BIT_LOOP       7
`define AMCR_BIT_SIX_CH     15
`define AMCR_BIT_MIC_SWAP   14
`define AMCR_GAIN_ZERO_DB   5'h08
`endif

// ### amcr_pkg.sv
// Purpose: shared types for the mixer control bank
// Assumes: nothing
// Notes:   one-hot apb slave states
package amcr_pkg;
	typedef logic [15:0] amcr_word_t;
	typedef enum logic [1:0] {
		AMCR_IDLE   = 2'b01,
		AMCR_ACCESS = 2'b10
	} amcr_state_e;
	typedef enum logic [2:0] {
		AMCR_SRC_MIC    = 3'h0,
		AMCR_SRC_CD     = 3'h1,
		AMCR_SRC_VIDEO  = 3'h2,
		AMCR_SRC_AUX    = 3'h3,
		AMCR_SRC_LINE   = 3'h4,
		AMCR_SRC_STEREO = 3'h5,
		AMCR_SRC_MONO   = 3'h6,
		AMCR_SRC_PHONE  = 3'h7
	} amcr_rec_src_e;
	typedef enum logic [1:0] {
		AMCR_DR_SLOTS_10_12 = 2'b00,
		AMCR_DR_SLOTS_7_8   = 2'b01
	} amcr_slot_sel_e;
endpackage

// ### amcr_chan.sv
// Purpose: one mixer input register with mute-gated gain outputs
// Assumes: write mask keeps reserved bits at zero
// Notes:   gain code is kept while muted
`timescale 1ns/1ps
`include "amcr_cfg.svh"
module amcr_chan #(
	parameter logic [15:0] RST_VAL = 16'h8808,
	parameter logic [15:0] MASK    = 16'h9f1f
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 clk_en,
	input  wire logic                 soft_rst,
	input  wire logic                 wr_en,
	input  wire logic [15:0]          wr_data,
	output logic      [15:0]          value,
	output logic                      muted,
	output logic      [4:0]           left_eff,
	output logic      [4:0]           right_eff
);
	import amcr_pkg::*;
	logic [15:0] value_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= RST_VAL;
		end else if (clk_en) begin
			if (soft_rst) begin
				value_reg <= RST_VAL;
			end else if (wr_en) begin
				value_reg <= wr_data & MASK;
			end
		end
	end
	assign value = value_reg;
	assign muted = value_reg[`AMCR_BIT_MUTE];
	// muted path forces the quietest code; held code is untouched
	assign left_eff  = muted ? 5'h1f : value_reg[12:8];
	assign right_eff = muted ? 5'h1f : value_reg[4:0];
endmodule

// ### amcr_gain.sv
// Purpose: decode a mixer gain code into half-dB steps
// Assumes: 5-bit code, 1.5 dB per code
// Notes:   output is signed, units of 0.5 dB
`timescale 1ns/1ps
module amcr_gain (
	input  wire logic [4:0]   code,
	input  wire logic         boost,
	output logic signed [7:0] half_db
);
	logic signed [7:0] base;
	// code 0 is +12 dB, -1.5 dB per step, code 8 is 0 dB
	assign base    = 8'sd24 - 8'(signed'({3'b000, code}) * 3);
	// boost adds a fixed 20 dB
	assign half_db = boost ? base + 8'sd40 : base;
endmodule

// ### amcr_asserts.sv
// Purpose: field and bus checks on the mixer control bank
// Assumes: full byte strobes, clk_en high while writing
// Notes:   bound to amcr_regs by the bind at the foot
`timescale 1ns/1ps
module amcr_asserts (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    clk_en,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [11:0]             paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [3:0]              pstrb,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic [4:0]              line_left_gain,
	input wire logic [4:0]              line_right_gain,
	input wire logic signed [7:0]       mic_gain_half_db,
	input wire amcr_pkg::amcr_rec_src_e left_rec_source,
	input wire amcr_pkg::amcr_rec_src_e right_rec_source,
	input wire logic [3:0]              rec_left_gain,
	input wire logic                    rec_muted,
	input wire logic                    spatial_enable,
	input wire logic                    mono_out_is_mic,
	input wire logic                    converter_loop,
	input wire logic [1:0]              double_rate_slot_select,
	input wire logic                    slot_select_reserved
);
	import amcr_pkg::*;
	logic        wr;
	logic [31:0] wd_q;
	// write data is gone by the next edge, so keep a copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wd_q <= 32'h0000_0000;
		else
			wd_q <= pwdata;
	end
	assign wr = psel & penable & pready & pwrite & ~pslverr & clk_en & (pstrb[1:0] == 2'b11);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mute;
		wr && paddr == 12'h040 && pwdata[15] |=> line_left_gain == 5'h1f && line_right_gain == 5'h1f;
	endproperty
	a_mute: assert property (p_mute) else $error("muted line gain not forced");
	property p_split;
		wr && paddr == 12'h040 && !pwdata[15] |=> {line_left_gain, line_right_gain} == {wd_q[12:8], wd_q[4:0]};
	endproperty
	a_split: assert property (p_split) else $error("line gain fields wrong");
	property p_mic;
		wr && paddr == 12'h038 |=> int'(mic_gain_half_db) == 24 - 3 * int'(wd_q[4:0]) + 40 * int'(wd_q[6]);
	endproperty
	a_mic: assert property (p_mic) else $error("mic gain decode wrong");
	property p_rsrc;
		wr && paddr == 12'h068 |=> left_rec_source == wd_q[10:8] && right_rec_source == wd_q[2:0];
	endproperty
	a_rsrc: assert property (p_rsrc) else $error("record source wrong");
	property p_rgain;
		wr && paddr == 12'h070 |=> rec_muted == wd_q[15] && rec_left_gain == wd_q[11:8];
	endproperty
	a_rgain: assert property (p_rgain) else $error("record gain wrong");
	property p_gp;
		wr && paddr == 12'h080 |=> spatial_enable == wd_q[13] && mono_out_is_mic == wd_q[9] && converter_loop == wd_q[7];
	endproperty
	a_gp: assert property (p_gp) else $error("general controls wrong");
	property p_slot_sel;
		wr && paddr == 12'h080 |=> double_rate_slot_select == wd_q[11:10]
			&& slot_select_reserved == wd_q[11];
	endproperty
	a_slot_sel: assert property (p_slot_sel) else $error("slot select wrong");
	property p_soft;
		wr && paddr == 12'h000 |-> ##1 (rec_muted && !spatial_enable && line_left_gain == 5'h1f);
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset missed");
	property p_rd;
		psel && penable && !pwrite |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0000_0000);
	endproperty
	a_rd: assert property (p_rd) else $error("read data not clean");
endmodule
bind amcr_regs amcr_asserts chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_left_gain(line_left_gain),
	.line_right_gain(line_right_gain), .mic_gain_half_db(mic_gain_half_db),
	.left_rec_source(left_rec_source), .right_rec_source(right_rec_source),
	.rec_left_gain(rec_left_gain), .rec_muted(rec_muted), .spatial_enable(spatial_enable),
	.mono_out_is_mic(mono_out_is_mic), .converter_loop(converter_loop),
	.double_rate_slot_select(double_rate_slot_select),
	.slot_select_reserved(slot_select_reserved));

// ### amcr_apb_ctrl.sv
// Purpose: controller-side apb master driving the bank
// Assumes: one transfer at a time, idle cycle between
// Notes:   wait for pready is bounded; ok low means a hang
`timescale 1ns/1ps
module amcr_apb_ctrl (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output bit ok);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		ok = 1'b0;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge pclk);
			ok = pready;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus must not keep showing the old value
		pwdata <= ~d;
		paddr <= ~a;
		@(posedge pclk);
	endtask
endmodule

// ### tb.sv
// Purpose: self-checking bench for the mixer control bank
// Assumes: zero-wait slave, full strobes apart from one byte-lane-0 write
// Notes:   shadow copy of every register except the reset register predicts reads
`timescale 1ns/1ps
module tb;
	import amcr_pkg::*;
	localparam logic [11:0] ADDR [12] = '{12'h030, 12'h038, 12'h040, 12'h048, 12'h050,
		12'h058, 12'h060, 12'h068, 12'h070, 12'h080, 12'h088, 12'h1e8};
	localparam logic [15:0] MSK [12] = '{16'h801f, 16'h805f, 16'h9f1f, 16'h9f1f, 16'h9f1f,
		16'h9f1f, 16'h9f1f, 16'h0707, 16'h8f0f, 16'h2f80, 16'h000f, 16'hc000};
	localparam logic [15:0] RST [12] = '{16'h8008, 16'h8008, 16'h8808, 16'h8808, 16'h8808,
		16'h8808, 16'h8808, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, rd, wd;
	logic [4:0]           line_left_gain, line_right_gain, cd_left_gain, cd_right_gain;
	logic [4:0]           video_left_gain, video_right_gain, aux_left_gain, aux_right_gain;
	logic [4:0]           pcm_left_gain, pcm_right_gain;
	logic [15:0]          phone_ctrl, mic_ctrl;
	logic [3:0]           rec_left_gain, rec_right_gain, depth_level, strb;
	logic [1:0]           slot_sel, boost_left_mic, boost_right_mic;
	logic                 rec_muted, spatial_enable, slot_res, mono_out_is_mic;
	logic                 converter_loop, shared_pins_outputs;
	logic signed [7:0]    mic_gain_half_db;
	amcr_rec_src_e        left_rec_source, right_rec_source;
	logic [15:0]          shadow [12];
	int                   mismatches, checked, seed, i, c;
	bit                   ok;
	amcr_apb_ctrl ctrl_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	amcr_regs dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .phone_ctrl(phone_ctrl),
		.mic_ctrl(mic_ctrl), .line_left_gain(line_left_gain),
		.line_right_gain(line_right_gain), .cd_left_gain(cd_left_gain),
		.cd_right_gain(cd_right_gain), .video_left_gain(video_left_gain),
		.video_right_gain(video_right_gain), .aux_left_gain(aux_left_gain),
		.aux_right_gain(aux_right_gain), .pcm_left_gain(pcm_left_gain),
		.pcm_right_gain(pcm_right_gain), .mic_gain_half_db(mic_gain_half_db),
		.left_rec_source(left_rec_source), .right_rec_source(right_rec_source),
		.rec_left_gain(rec_left_gain), .rec_right_gain(rec_right_gain),
		.rec_muted(rec_muted), .spatial_enable(spatial_enable), .depth_level(depth_level),
		.double_rate_slot_select(slot_sel), .slot_select_reserved(slot_res),
		.mono_out_is_mic(mono_out_is_mic), .converter_loop(converter_loop),
		.boost_left_mic(boost_left_mic), .boost_right_mic(boost_right_mic),
		.shared_pins_outputs(shared_pins_outputs));
	function automatic logic [4:0] eff(input logic [15:0] v);
		return v[15] ? 5'h1f : v[12:8];
	endfunction
	function automatic logic [9:0] eff2(input logic [15:0] v);
		return v[15] ? 10'h3ff : {v[12:8], v[4:0]};
	endfunction
	function automatic logic [3:0] mic_route(input int k);
		logic [31:0] tbl;
		// left then right mic per routing code: 0 mic1, 1 mic2, 2 mic3
		tbl = 32'h10aa_1520;
		return tbl[4*k +: 4];
	endfunction
	task automatic end_of_test();
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		// random idle gaps vary the spacing of requests
		repeat ($unsigned($random(seed)) % 3) @(posedge pclk);
		ctrl_u.xfer(w, a, d, rd, err, ok);
		if (!ok) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic check_all();
		int j;
		for (j = 0; j < 12; j++) begin
			bus(1'b0, ADDR[j], 32'h0000_0000);
			chk(rd, {16'h0000, shadow[j]});
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		seed = 32'hd495_b4de;
		mismatches = 0;
		checked = 0;
		presetn = 1'b0;
		strb = 4'hf;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 12; i++)
			shadow[i] = RST[i];
		check_all();
		for (i = 0; i < 60; i++) begin
			c = $unsigned($random(seed)) % 12;
			wd = $random(seed);
			bus(1'b1, ADDR[c], wd);
			shadow[c] = wd[15:0] & MSK[c];
			bus(1'b0, ADDR[c], 32'h0000_0000);
			chk(rd, {16'h0000, shadow[c]});
			chk(line_left_gain, eff(shadow[2]));
			chk({line_left_gain, line_right_gain}, eff2(shadow[2]));
			chk({cd_left_gain, cd_right_gain}, eff2(shadow[3]));
			chk({video_left_gain, video_right_gain}, eff2(shadow[4]));
			chk({aux_left_gain, aux_right_gain}, eff2(shadow[5]));
			chk({pcm_left_gain, pcm_right_gain}, eff2(shadow[6]));
			chk({phone_ctrl, mic_ctrl}, {shadow[0], shadow[1]});
			chk(right_rec_source, shadow[7][2:0]);
			chk({rec_muted, rec_left_gain}, {shadow[8][15], shadow[8][11:8]});
			chk(rec_right_gain, shadow[8][3:0]);
			chk({spatial_enable, depth_level}, {shadow[9][13], shadow[10][3:0]});
			chk({slot_sel, slot_res}, {shadow[9][11:10], shadow[9][11]});
			chk({mono_out_is_mic, converter_loop}, {shadow[9][9], shadow[9][7]});
		end
		bus(1'b1, 12'h040, 32'h0000_8305);
		chk({line_left_gain, line_right_gain}, 10'h3ff);
		bus(1'b1, 12'h040, 32'h0000_0305);
		chk({line_left_gain, line_right_gain}, {5'h03, 5'h05});
		strb <= 4'h1;
		bus(1'b1, 12'h040, 32'h0000_ff11);
		strb <= 4'hf;
		chk({line_left_gain, line_right_gain}, {5'h03, 5'h11});
		for (c = 0; c < 64; c++) begin
			bus(1'b1, 12'h038, {25'h0, c[5], 1'b0, c[4:0]});
			chk(mic_gain_half_db, 24 - 3 * (c % 32) + 40 * (c / 32));
		end
		for (c = 0; c < 8; c++) begin
			bus(1'b1, 12'h068, {21'h0, c[2:0], 5'h00, ~c[2:0]});
			chk(left_rec_source, c);
		end
		for (c = 0; c < 8; c++) begin
			bus(1'b1, 12'h1e8, {16'h0000, c[2:1], 14'h0000});
			bus(1'b1, 12'h080, {23'h0, c[0], 8'h00});
			chk({boost_left_mic, boost_right_mic}, mic_route(c));
			chk(shared_pins_outputs, c[2]);
		end
		bus(1'b1, 12'h004, 32'hffff_ffff);
		chk(err, 1'b1);
		bus(1'b0, 12'h03a, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		bus(1'b1, 12'h000, 32'h0000_1234);
		for (i = 0; i < 12; i++)
			shadow[i] = RST[i];
		check_all();
		chk(line_left_gain, 5'h1f);
		end_of_test();
	end
endmodule
